// File: rtl/program_sequencer.sv
// Program sequencing core: PC, return stack, table reads, data map.
// Assumes the decoder presents one instruction per instruction cycle
// on instr_i, registered in clk_i, and that program memory answers
// rom_data_i one system clock after rom_addr_o.
`timescale 1ns/1ps
`include "sequencer_regs.svh"

module program_sequencer (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire sequencer_pkg::instr_type instr_i,
  input  wire logic                    skip_taken_i,
  input  wire logic                    irq_ext_i,
  input  wire logic                    irq_t0_i,
  input  wire logic                    irq_t1_i,
  input  wire logic [15:0]             rom_data_i,
  output logic [15:0]                  rom_addr_o,
  output logic [15:0]                  pc_o,
  output logic [7:0]                   rdata_o,
  output logic                         fetch_o,
  output logic                         ack_ext_o,
  output logic                         ack_t0_o,
  output logic                         ack_t1_o
);
  sequencer_pkg::state_type s_reg;
  sequencer_pkg::state_type s_next;

  // Data-map read: only this block's registers and general memory answer
  function automatic logic [7:0] map_read(input sequencer_pkg::state_type s,
                                          input logic [7:0] a);
    logic [7:0] r;
    r = `BYTE_RESET;
    if (a >= `OFS_GENERAL_FIRST) begin
      r = s.ram[a - `OFS_GENERAL_FIRST];
    end else begin
      case (a)
        `OFS_MEMORY_POINTER_0: r = s.mp0;
        `OFS_MEMORY_POINTER_1: r = s.mp1;
        `OFS_PC_LOW_BYTE:      r = s.pc[7:0];
        `OFS_TABLE_PTR_LOW:    r = s.table_pointer_low;
        `OFS_TABLE_HIGH:       r = s.table_high_result;
        `OFS_TABLE_PTR_HIGH:   r = s.table_pointer_high;
        default:               r = `BYTE_RESET;
      endcase
    end
    return r;
  endfunction

  // Resolves an indirect location to the byte its pointer names
  function automatic logic [7:0] resolve(input sequencer_pkg::state_type s,
                                         input logic [7:0] a);
    logic [7:0] r;
    r = a;
    if (a == `OFS_INDIRECT_0) begin
      r = s.mp0;
    end else if (a == `OFS_INDIRECT_1) begin
      r = s.mp1;
    end
    return r;
  endfunction

  // True when an indirect access lands back on an indirect location
  function automatic logic self_ref(input logic [7:0] a);
    return (a == `OFS_INDIRECT_0) || (a == `OFS_INDIRECT_1);
  endfunction

  // Stores one byte at a resolved address; read-only result is skipped
  function automatic sequencer_pkg::state_type map_write(
      input sequencer_pkg::state_type s, input logic [7:0] a, input logic [7:0] d);
    sequencer_pkg::state_type t;
    t = s;
    if (a >= `OFS_GENERAL_FIRST) begin
      t.ram[a - `OFS_GENERAL_FIRST] = d;
    end else begin
      case (a)
        `OFS_MEMORY_POINTER_0: t.mp0 = d;
        `OFS_MEMORY_POINTER_1: t.mp1 = d;
        `OFS_PC_LOW_BYTE:      t.pc = {s.pc[15:8], d};
        `OFS_TABLE_PTR_LOW:    t.table_pointer_low = d;
        `OFS_TABLE_PTR_HIGH:   t.table_pointer_high = d;
        default:               t.table_pointer_low = s.table_pointer_low; // Result register ignores writes
      endcase
    end
    return t;
  endfunction

  // Pushes a return address; the pointer wraps and drops the oldest
  function automatic sequencer_pkg::state_type push(
      input sequencer_pkg::state_type s, input logic [15:0] v);
    sequencer_pkg::state_type t;
    t = s;
    t.stack[s.sp] = v;
    t.sp = s.sp + 3'h1;
    if (s.depth != 4'(`STACK_DEPTH)) begin
      t.depth = s.depth + 4'h1;
    end
    return t;
  endfunction

  logic [7:0] eff_addr;
  logic       stack_full;
  logic       pc_low_hit;
  logic [2:0] top_idx;

  assign stack_full = (s_reg.depth == 4'(`STACK_DEPTH));
  assign eff_addr   = resolve(s_reg, instr_i.addr);
  // An indirect write that lands on the low PC byte is a short jump as well
  assign pc_low_hit = (instr_i.op == sequencer_pkg::OP_DATA_WR) &&
                      (eff_addr == `OFS_PC_LOW_BYTE);
  assign top_idx    = s_reg.sp - 3'h1;

  // Next-state logic; decisions are made on the last phase of each cycle
  always_comb begin
    s_next = s_reg;
    s_next.ack_ext = 1'b0;
    s_next.ack_t0  = 1'b0;
    s_next.ack_t1  = 1'b0;
    s_next.fetch   = 1'b0;
    s_next.tick = s_reg.tick + 2'h1; // Four system clocks per cycle
    // Reads are registered every system clock off the live map for the decoder
    s_next.rdata = self_ref(instr_i.addr) && self_ref(eff_addr) ? `BYTE_RESET
                   : map_read(s_reg, self_ref(eff_addr) ? `BYTE_RESET : eff_addr);
    if (self_ref(instr_i.addr) && self_ref(eff_addr)) begin
      s_next.rdata = `BYTE_RESET;
    end
    if (s_reg.tick == 2'h3) begin
      case (s_reg.phase)
        sequencer_pkg::ST_IDLE: begin
          s_next.phase = sequencer_pkg::ST_FETCH; // Refill slot
        end
        sequencer_pkg::ST_TABLE: begin
          // Second cycle: word from program memory splits into two bytes
          if (!self_ref(s_reg.tab_addr)) begin
            s_next = map_write(s_next, s_reg.tab_addr, rom_data_i[7:0]);
          end
          s_next.table_high_result  = rom_data_i[15:8];
          s_next.rom_addr = s_reg.pc; // Program memory returns to fetching
          s_next.phase = sequencer_pkg::ST_FETCH;
        end
        sequencer_pkg::ST_FETCH: begin
          s_next.fetch = 1'b1;
          s_next.pc = s_reg.pc + 16'h0001;
          if (!stack_full && (irq_ext_i || irq_t0_i || irq_t1_i)) begin
            // Interrupt entry takes priority; full stack holds it off
            s_next = push(s_next, s_reg.pc);
            if (irq_ext_i) begin
              s_next.pc = `VEC_EXTERNAL;
              s_next.ack_ext = 1'b1;
            end else if (irq_t0_i) begin
              s_next.pc = `VEC_TIMER0;
              s_next.ack_t0 = 1'b1;
            end else begin
              s_next.pc = `VEC_TIMER1;
              s_next.ack_t1 = 1'b1;
            end
            s_next.phase = sequencer_pkg::ST_IDLE;
          end else begin
            case (instr_i.op)
              sequencer_pkg::OP_SKIP: begin
                if (skip_taken_i) begin
                  // Step over the discarded word, staying inside the bank
                  s_next.pc = {s_reg.pc[15:13], s_reg.pc[12:0] + 13'h0002};
                  s_next.phase = sequencer_pkg::ST_IDLE;
                end
              end
              sequencer_pkg::OP_JUMP: begin
                s_next.pc = instr_i.target;
                s_next.phase = sequencer_pkg::ST_IDLE;
              end
              sequencer_pkg::OP_CALL: begin
                s_next = push(s_next, s_reg.pc + 16'h0001);
                s_next.pc = instr_i.target;
                s_next.phase = sequencer_pkg::ST_IDLE;
              end
              sequencer_pkg::OP_RETURN, sequencer_pkg::OP_INTERRUPT_RETURN: begin
                s_next.pc = s_reg.stack[top_idx];
                s_next.sp = top_idx;
                if (s_reg.depth != 4'h0) begin
                  s_next.depth = s_reg.depth - 4'h1; // Frees a level
                end
                s_next.phase = sequencer_pkg::ST_IDLE;
              end
              sequencer_pkg::OP_TAB_PAGED: begin
                s_next.rom_addr = {s_reg.table_pointer_high, s_reg.table_pointer_low};
                s_next.tab_addr = eff_addr;
                s_next.phase = sequencer_pkg::ST_TABLE;
              end
              sequencer_pkg::OP_TAB_LAST: begin
                s_next.rom_addr = {`LAST_PAGE_BYTE, s_reg.table_pointer_low};
                s_next.tab_addr = eff_addr;
                s_next.phase = sequencer_pkg::ST_TABLE;
              end
              sequencer_pkg::OP_DATA_WR: begin
                if (!self_ref(eff_addr)) begin
                  s_next = map_write(s_next, eff_addr, instr_i.wdata);
                end
                if (pc_low_hit) begin
                  s_next.pc = {s_reg.pc[15:8], instr_i.wdata};
                  s_next.phase = sequencer_pkg::ST_IDLE;
                end
              end
              default: begin
                s_next.phase = sequencer_pkg::ST_FETCH;
              end
            endcase
          end
          if (s_next.phase != sequencer_pkg::ST_TABLE) begin
            s_next.rom_addr = s_next.pc;
          end
        end
        default: begin
          s_next.phase = sequencer_pkg::ST_FETCH;
        end
      endcase
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0; // PC 000H, stack empty, pointer at entry 0
    end else begin
      s_reg <= s_next;
    end
  end

  assign rom_addr_o = s_reg.rom_addr;
  assign pc_o       = s_reg.pc;
  assign rdata_o    = s_reg.rdata;
  assign fetch_o    = s_reg.fetch;
  assign ack_ext_o  = s_reg.ack_ext;
  assign ack_t0_o   = s_reg.ack_t0;
  assign ack_t1_o   = s_reg.ack_t1;

  // Checks
  sequence s_taken_jump;
    s_reg.tick == 2'h3 && s_reg.phase == sequencer_pkg::ST_FETCH &&
    !((irq_ext_i || irq_t0_i || irq_t1_i) && !stack_full) &&
    instr_i.op == sequencer_pkg::OP_JUMP;
  endsequence

  // Decision edge on which the instruction itself is carried out
  sequence s_decide;
    s_reg.tick == 2'h3 && s_reg.phase == sequencer_pkg::ST_FETCH &&
    !((irq_ext_i || irq_t0_i || irq_t1_i) && !stack_full);
  endsequence

  sequence s_taken_skip;
    s_decide ##0 (instr_i.op == sequencer_pkg::OP_SKIP && skip_taken_i);
  endsequence

  sequence s_taken_return;
    s_decide ##0 (instr_i.op == sequencer_pkg::OP_RETURN ||
                  instr_i.op == sequencer_pkg::OP_INTERRUPT_RETURN);
  endsequence

  sequence s_pcl_write;
    s_decide ##0 pc_low_hit;
  endsequence

  chk_skip_two_ahead: assert property (@(posedge clk_i) disable iff (rst_i)
    s_taken_skip |=> s_reg.pc[12:0] == $past(s_reg.pc[12:0]) + 13'h0002 &&
    s_reg.pc[15:13] == $past(s_reg.pc[15:13]) && s_reg.phase == sequencer_pkg::ST_IDLE)
    else $error("Taken skip did not step over the next word");

  chk_idle_no_fetch: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.phase == sequencer_pkg::ST_IDLE && s_reg.tick == 2'h3
    |=> !fetch_o && pc_o == $past(pc_o) && s_reg.phase == sequencer_pkg::ST_FETCH)
    else $error("Refill slot fetched or moved the PC");

  chk_return_pop: assert property (@(posedge clk_i) disable iff (rst_i)
    s_taken_return |=> s_reg.sp == $past(s_reg.sp) - 3'h1 &&
    s_reg.phase == sequencer_pkg::ST_IDLE)
    else $error("Return did not pop the stack");

  chk_pcl_short_jump: assert property (@(posedge clk_i) disable iff (rst_i)
    s_pcl_write |=> s_reg.pc == {$past(s_reg.pc[15:8]), $past(instr_i.wdata)} &&
    s_reg.phase == sequencer_pkg::ST_IDLE)
    else $error("Low byte write did not jump within the page");

  chk_table_high_load: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.phase == sequencer_pkg::ST_TABLE && s_reg.tick == 2'h3
    |=> s_reg.table_high_result == $past(rom_data_i[15:8]) && s_reg.phase == sequencer_pkg::ST_FETCH)
    else $error("Table high byte not loaded at end of table cycle");

  chk_tick_cadence: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> s_reg.tick == $past(s_reg.tick) + 2'h1)
    else $error("Phase counter skipped a system clock");

  chk_irq_push: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_ext_o || ack_t0_o || ack_t1_o |-> s_reg.depth == $past(s_reg.depth) + 4'h1)
    else $error("Interrupt entry did not push the PC");

  chk_reset_pc_zero: assert property (@(posedge clk_i)
    $past(rst_i) |-> s_reg.pc == `VEC_RESET && s_reg.depth == 4'h0)
    else $error("PC or stack not cleared by reset");

  chk_jump_idle_slot: assert property (@(posedge clk_i) disable iff (rst_i)
    s_taken_jump |=> s_reg.pc == $past(instr_i.target) &&
    s_reg.phase == sequencer_pkg::ST_IDLE)
    else $error("Jump did not load target with idle slot");

  chk_pc_increment: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.tick == 2'h3 && s_reg.phase == sequencer_pkg::ST_FETCH &&
    instr_i.op == sequencer_pkg::OP_NEXT && !irq_ext_i && !irq_t0_i && !irq_t1_i
    |=> s_reg.pc == $past(s_reg.pc) + 16'h0001)
    else $error("PC did not advance by one");

  chk_ext_vector: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_ext_o |-> pc_o == `VEC_EXTERNAL)
    else $error("External entry not at its vector");

  chk_timer_vectors: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_t0_o |-> pc_o == `VEC_TIMER0) and (ack_t1_o |-> pc_o == `VEC_TIMER1))
    else $error("Timer entry not at its vector");

  chk_full_holds_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    stack_full && s_reg.tick == 2'h3 |=> !ack_ext_o && !ack_t0_o && !ack_t1_o)
    else $error("Interrupt taken with stack full");

  chk_table_two_cycles: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.phase == sequencer_pkg::ST_FETCH && $past(s_reg.phase) == sequencer_pkg::ST_TABLE
    |-> $past(s_reg.phase, 4) == sequencer_pkg::ST_TABLE)
    else $error("Table read slot shorter than one cycle");

  chk_depth_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.depth <= 4'(`STACK_DEPTH))
    else $error("Stack depth beyond eight");
endmodule

// File: rtl/sequencer_regs.svh
// Offsets, reset values and timing counts for the program sequencer.
// Assumes inclusion by bare name from a package or module.
`ifndef SEQUENCER_REGS_SVH
`define SEQUENCER_REGS_SVH
`define OFS_INDIRECT_0       8'h00
`define OFS_MEMORY_POINTER_0 8'h01
`define OFS_INDIRECT_1       8'h02
`define OFS_MEMORY_POINTER_1 8'h03
`define OFS_PC_LOW_BYTE      8'h06
`define OFS_TABLE_PTR_LOW    8'h07
`define OFS_TABLE_HIGH       8'h08
`define OFS_TABLE_PTR_HIGH   8'h1F
`define OFS_GENERAL_FIRST    8'h20
`define VEC_RESET            16'h0000
`define VEC_EXTERNAL         16'h0004
`define VEC_TIMER0           16'h0008
`define VEC_TIMER1           16'h000C
`define LAST_PAGE_BYTE       8'h9F
`define PROGRAM_WORDS        17'h0A000
`define BANK_WORDS           16'h2000
`define STACK_DEPTH          8
`define PHASES_PER_CYCLE     3'h4
`define TABLE_READ_CYCLES    2'h2
`define BYTE_RESET           8'h00
`endif

// File: rtl/sequencer_pkg.sv
// Types shared by the program sequencer.
// Assumes the constants header sits in the include path.
package sequencer_pkg;
  typedef enum logic [3:0] {
    OP_NEXT      = 4'h0,
    OP_SKIP      = 4'h1,
    OP_JUMP      = 4'h2,
    OP_CALL      = 4'h3,
    OP_RETURN    = 4'h4,
    OP_INTERRUPT_RETURN      = 4'h5,
    OP_TAB_PAGED = 4'h6,
    OP_TAB_LAST  = 4'h7,
    OP_DATA_WR   = 4'h8
  } op_type;

  typedef enum logic [1:0] {
    ST_FETCH = 2'h0,
    ST_IDLE  = 2'h1,
    ST_TABLE = 2'h2
  } phase_type;

  typedef struct packed {
    op_type      op;
    logic [15:0] target;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } instr_type;

  typedef struct packed {
    logic [15:0]      pc;
    logic [2:0]       sp;
    logic [3:0]       depth;
    logic [7:0][15:0] stack;
    logic [7:0]       mp0;
    logic [7:0]       mp1;
    logic [7:0]       table_pointer_low;
    logic [7:0]       table_pointer_high;
    logic [7:0]       table_high_result;
    logic [223:0][7:0] ram;
    logic [1:0]       tick;
    phase_type        phase;
    logic [7:0]       tab_addr;
    logic [15:0]      rom_addr;
    logic [7:0]       rdata;
    logic             ack_ext;
    logic             ack_t0;
    logic             ack_t1;
    logic             fetch;
  } state_type;
endpackage

// File: tb/program_sequencer_stack_table_read_test.sv
// Self-checking bench for the program sequencer: fetch, transfers, stack, tables, data map.
// Assumes the sequencer package, constants header and design module are compiled first.
`timescale 1ns/1ps
`include "sequencer_regs.svh"

module program_sequencer_stack_table_read_test;
  logic                     clk_i;
  logic                     rst_i;
  sequencer_pkg::instr_type instr_i;
  logic                     skip_taken_i;
  logic                     irq_ext_i;
  logic                     irq_t0_i;
  logic                     irq_t1_i;
  logic [15:0]              rom_data_i;
  logic [15:0]              rom_addr_o;
  logic [15:0]              pc_o;
  logic [7:0]               rdata_o;
  logic                     fetch_o;
  logic                     ack_ext_o;
  logic                     ack_t0_o;
  logic                     ack_t1_o;
  int                       errors;
  int                       tests_run;
  logic [15:0]              lfsr;
  logic [15:0]              w;
  logic [2:0]               g_irq;
  logic [15:0]              m_pc;
  logic [15:0]              m_stk [8];
  int                       m_sp;
  int                       m_depth;
  logic                     m_busy;
  logic [7:0]               m_table_pointer_low;
  logic [7:0]               m_table_pointer_high;

  program_sequencer dut (
    .clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i), .skip_taken_i(skip_taken_i),
    .irq_ext_i(irq_ext_i), .irq_t0_i(irq_t0_i), .irq_t1_i(irq_t1_i),
    .rom_data_i(rom_data_i), .rom_addr_o(rom_addr_o), .pc_o(pc_o), .rdata_o(rdata_o),
    .fetch_o(fetch_o), .ack_ext_o(ack_ext_o), .ack_t0_o(ack_t0_o), .ack_t1_o(ack_t1_o));

  // 50 ns period; the program memory answers one clock after the address
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) rom_data_i <= rom_word(rom_addr_o);

  // Word content derived from its address, so every table byte is predictable
  function automatic logic [15:0] rom_word(input logic [15:0] a);
    return {a[7:0] ^ 8'h5A, a[15:8] ^ 8'hC3};
  endfunction

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Counts: errors %0d comparisons %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Reset leaves the bench aligned so the next slot's fourth edge is the decision edge
  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    m_pc = 16'h0; m_sp = 0; m_depth = 0; m_busy = 1'b0; g_irq = 3'h0;
    @(negedge clk_i);
    check(pc_o, `VEC_RESET);
    check(rom_addr_o, `VEC_RESET);
  endtask

  // One instruction slot of four clocks; the model predicts and compares its outcome
  task automatic exec(input sequencer_pkg::op_type op, input logic [15:0] tgt,
                      input logic [7:0] a, input logic [7:0] d, input logic skip);
    logic        was_busy;
    logic        pc_ok;
    logic        tab;
    logic [2:0]  ack;
    logic [15:0] rom;
    @(posedge clk_i);
    instr_i <= '{op: op, target: tgt, addr: a, wdata: d};
    skip_taken_i <= skip;
    {irq_ext_i, irq_t0_i, irq_t1_i} <= g_irq;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    was_busy = m_busy;
    pc_ok = ~was_busy;
    tab = 1'b0;
    m_busy = 1'b0;
    ack = 3'h0;
    if (!was_busy && m_depth < 8 && g_irq != 3'h0) begin
      ack = g_irq[2] ? 3'b100 : (g_irq[1] ? 3'b010 : 3'b001);
    end
    if (was_busy) begin
    end else if (ack != 3'h0) begin
      m_stk[m_sp] = m_pc; m_sp = (m_sp + 1) % 8; m_depth++; m_busy = 1'b1;
      m_pc = ack[2] ? `VEC_EXTERNAL : (ack[1] ? `VEC_TIMER0 : `VEC_TIMER1);
      g_irq = g_irq & ~ack;
    end else begin
      m_pc = m_pc + 16'h1;
      case (op)
        sequencer_pkg::OP_SKIP: if (skip) begin
          m_pc = m_pc + 16'h1; m_busy = 1'b1;
        end
        sequencer_pkg::OP_JUMP: begin
          m_pc = tgt; m_busy = 1'b1;
        end
        sequencer_pkg::OP_CALL: begin
          m_stk[m_sp] = m_pc; m_sp = (m_sp + 1) % 8; m_busy = 1'b1;
          m_depth = (m_depth < 8) ? m_depth + 1 : 8; m_pc = tgt;
        end
        sequencer_pkg::OP_RETURN, sequencer_pkg::OP_INTERRUPT_RETURN: begin
          m_sp = (m_sp + 7) % 8; m_pc = m_stk[m_sp]; m_depth--; m_busy = 1'b1;
        end
        sequencer_pkg::OP_TAB_PAGED, sequencer_pkg::OP_TAB_LAST: begin
          tab = 1'b1; m_busy = 1'b1;
          rom = {(op == sequencer_pkg::OP_TAB_LAST) ? `LAST_PAGE_BYTE : m_table_pointer_high, m_table_pointer_low};
        end
        sequencer_pkg::OP_DATA_WR: begin
          if (a == `OFS_PC_LOW_BYTE) begin
            m_pc = {m_pc[15:8] - {7'h0, m_pc[7:0] == 8'h00}, d}; m_busy = 1'b1;
          end
          if (a == `OFS_TABLE_PTR_LOW) m_table_pointer_low = d;
          if (a == `OFS_TABLE_PTR_HIGH) m_table_pointer_high = d;
        end
        default: ;
      endcase
    end
    check({15'h0, fetch_o}, {15'h0, ~was_busy});
    check({13'h0, ack_ext_o, ack_t0_o, ack_t1_o}, {13'h0, ack});
    if (pc_ok) check(pc_o, m_pc);
    if (tab) check(rom_addr_o, rom);
    else if (pc_ok) check(rom_addr_o, m_pc);
  endtask

  task automatic nxt(input logic [7:0] a);
    exec(sequencer_pkg::OP_NEXT, 16'h0, a, 8'h00, 1'b0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    exec(sequencer_pkg::OP_DATA_WR, 16'h0, a, d, 1'b0);
  endtask

  // Each call is followed by its idle refill slot
  task automatic calls(input int n);
    for (int k = 0; k < n; k++) begin
      lfsr = lfsr_next(lfsr);
      exec(sequencer_pkg::OP_CALL, {3'h0, lfsr[12:0]}, 8'h00, 8'h00, 1'b0);
      nxt(8'h00);
    end
  endtask

  initial begin
    clk_i = 1'b0; rst_i = 1'b1; instr_i = '0; skip_taken_i = 1'b0; rom_data_i = 16'h0;
    irq_ext_i = 1'b0; irq_t0_i = 1'b0; irq_t1_i = 1'b0; errors = 0; tests_run = 0;
    lfsr = 16'h001D; m_table_pointer_low = 8'h00; m_table_pointer_high = 8'h00;
    do_reset();
    // Random bytes through general data memory, with its two boundary addresses
    for (int k = 0; k < 8; k++) begin
      lfsr = lfsr_next(lfsr);
      w[7:0] = (k == 0) ? 8'h20 : ((k == 1) ? 8'hFF : 8'h20 + {1'b0, lfsr[6:0]});
      wr(w[7:0], lfsr[15:8]);
      nxt(w[7:0]);
      check({8'h00, rdata_o}, {8'h00, lfsr[15:8]});
    end
    // Indirect access through both pointers, then a pointer aimed at itself
    wr(`OFS_MEMORY_POINTER_0, 8'h30); wr(`OFS_INDIRECT_0, 8'h6B); nxt(8'h30);
    check({8'h00, rdata_o}, 16'h006B);
    wr(`OFS_MEMORY_POINTER_1, 8'h30); nxt(`OFS_INDIRECT_1);
    check({8'h00, rdata_o}, 16'h006B);
    wr(`OFS_MEMORY_POINTER_0, `OFS_INDIRECT_0); wr(`OFS_INDIRECT_0, 8'hE7); nxt(`OFS_INDIRECT_0);
    check({8'h00, rdata_o}, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      nxt(k[1] ? (k[0] ? 8'h1E : 8'h18) : (k[0] ? 8'h09 : 8'h05));
      check({8'h00, rdata_o}, 16'h0000);
    end
    // Both table-read kinds, with a refused write to the result register
    for (int j = 0; j < 2; j++) begin
      lfsr = lfsr_next(lfsr);
      wr(`OFS_TABLE_PTR_LOW, lfsr[7:0]); wr(`OFS_TABLE_PTR_HIGH, lfsr[15:8]);
      exec(j ? sequencer_pkg::OP_TAB_LAST : sequencer_pkg::OP_TAB_PAGED, 16'h0, 8'h50, 8'h0, 1'b0);
      w = rom_word({j ? `LAST_PAGE_BYTE : lfsr[15:8], lfsr[7:0]});
      nxt(8'h00);
      wr(`OFS_TABLE_HIGH, ~w[15:8]);
      nxt(`OFS_TABLE_HIGH);
      check({8'h00, rdata_o}, {8'h00, w[15:8]});
      nxt(8'h50);
      check({8'h00, rdata_o}, {8'h00, w[7:0]});
      nxt(`OFS_TABLE_PTR_HIGH);
      check({8'h00, rdata_o}, {8'h00, lfsr[15:8]});
    end
    // Transfers: jump, skip taken and not, low-byte write; all but the untaken skip have a refill slot
    lfsr = lfsr_next(lfsr);
    exec(sequencer_pkg::OP_JUMP, {3'h0, lfsr[12:0]}, 8'h00, 8'h00, 1'b0); nxt(8'h00); nxt(8'h00);
    exec(sequencer_pkg::OP_SKIP, 16'h0, 8'h00, 8'h00, 1'b1); nxt(8'h00); nxt(8'h00);
    exec(sequencer_pkg::OP_SKIP, 16'h0, 8'h00, 8'h00, 1'b0); nxt(8'h00);
    wr(`OFS_PC_LOW_BYTE, lfsr[15:8]); nxt(8'h00); nxt(8'h00);
    // Nine calls overflow the stack; eight returns give back the newest eight
    calls(9);
    for (int k = 0; k < 8; k++) begin
      exec(k[0] ? sequencer_pkg::OP_INTERRUPT_RETURN : sequencer_pkg::OP_RETURN, 16'h0, 8'h0, 8'h0, 1'b0);
      nxt(8'h00);
    end
    // Full stack holds off a pending request until a return frees a level
    calls(8);
    g_irq = 3'b010; nxt(8'h00);
    exec(sequencer_pkg::OP_RETURN, 16'h0, 8'h00, 8'h00, 1'b0); nxt(8'h00); nxt(8'h00);
    // All three requests at once are served in priority order
    do_reset();
    g_irq = 3'b111;
    for (int k = 0; k < 6; k++) nxt(8'h00);
    complete_run();
  end
endmodule
